// File: rtl/rfps_defs.svh
// Register offset, control bit positions and reset value for the RF port switch block
`ifndef RFPS_DEFS_SVH
`define RFPS_DEFS_SVH
`define RFPS_CTRL_B_ADDR     6'h07
`define RFPS_PORT_MODE_BIT   12
`define RFPS_INVERT_BIT      13
`define RFPS_BIAS_EN_BIT     14
`define RFPS_CTRL_B_RESET    16'h0000
`endif

// File: rtl/rfps_pkg.sv
// Types shared by the RF port switch block
package rfps_pkg;
	typedef enum logic [2:0] {
		RFPS_IDLE,
		RFPS_LOWPWR,
		RFPS_CCA,
		RFPS_RX,
		RFPS_TX
	} rfps_radio_state_type;

	typedef struct packed {
		logic port_mode_select;
		logic bias_out_invert;
		logic bias_out_enable;
	} rfps_ctrl_type;

	typedef struct packed {
		logic rx_switch_en;
		logic lna_en;
		logic single_pa_en;
		logic dual_pa_en;
	} rfps_path_type;
endpackage

// File: rtl/rfps_core.sv
// RF port mode, receive switch, PA gating and switched bias output control
// Contract
// R1: Bit 12: 0 dual-port default, 1 single-port
// R2: Bit 14 enables bias output, else tri-stated
// R3: Bit 13 inverts only in dual-port mode
// R4: Single-port receive: switch to LNA, PA off
// R5: Single-port transmit: switch open, PA on
// R6: Single-port enabled bias: high TX, low RX
// R7: Bias high only during CCA, RX, TX
// R8: Dual-port: RF pair receive, separate PA transmits
// R9: Dual-port bias follows transmit versus receive state
// R10: Dual-port: TX high, RX low, invert swaps
// R11: Enabled bias driven low when idle
`timescale 1ns/1ns
`include "rfps_defs.svh"
module rfps_core (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          reg_wr,
	input  wire logic [5:0]                    reg_addr,
	input  wire logic [15:0]                   reg_wdata,
	output logic      [15:0]                   reg_rdata,
	input  wire rfps_pkg::rfps_radio_state_type radio_state,
	output rfps_pkg::rfps_path_type            path_ctl,
	output logic                               switch_bias_output,
	output logic                               switch_bias_oe
);
	import rfps_pkg::*;

	logic [15:0]   ctrl_b_ff;
	logic [15:0]   reg_rdata_ff;
	rfps_path_type path_ff;
	logic          bias_ff;
	logic          bias_oe_ff;

	wire           sel_ctrl_b = (reg_addr == `RFPS_CTRL_B_ADDR);
	wire           wr_ctrl_b  = reg_wr && sel_ctrl_b;
	// Bits outside the three control fields are kept so software reads back its word
	wire [15:0]    nxt_ctrl_b = wr_ctrl_b ? reg_wdata : ctrl_b_ff; // R1
	rfps_ctrl_type ctrl;
	assign ctrl.port_mode_select = ctrl_b_ff[`RFPS_PORT_MODE_BIT]; // R1
	assign ctrl.bias_out_invert  = ctrl_b_ff[`RFPS_INVERT_BIT];
	assign ctrl.bias_out_enable  = ctrl_b_ff[`RFPS_BIAS_EN_BIT];

	wire is_tx     = (radio_state == RFPS_TX);
	wire is_rx     = (radio_state == RFPS_RX) || (radio_state == RFPS_CCA);
	wire seq_active = is_tx || is_rx;

	// Single-port ignores invert; dual-port polarity follows invert
	wire bias_active_lvl = ctrl.port_mode_select ? is_tx : (is_tx ^ ctrl.bias_out_invert); // R3 R6 R9 R10
	// Low outside sequences so an external switch never floats while bias is enabled
	wire nxt_bias    = seq_active && bias_active_lvl; // R7 R11
	wire nxt_bias_oe = ctrl.bias_out_enable; // R2

	// Dual-port keeps the receive switch closed; transmit leaves by the separate PA
	rfps_path_type nxt_path;
	assign nxt_path.rx_switch_en = ctrl.port_mode_select ? is_rx : 1'h1; // R4 R5 R8
	assign nxt_path.lna_en       = is_rx; // R4 R8
	assign nxt_path.single_pa_en = ctrl.port_mode_select && is_tx; // R5 R8
	assign nxt_path.dual_pa_en   = !ctrl.port_mode_select && is_tx; // R8

	wire [15:0] nxt_rdata = sel_ctrl_b ? ctrl_b_ff : 16'h0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_b_ff <= `RFPS_CTRL_B_RESET; // R1 R2 R3
		end else begin
			ctrl_b_ff <= nxt_ctrl_b;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			path_ff <= '0;
		end else begin
			path_ff <= nxt_path; // R4 R5 R8
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bias_ff <= 1'h0;
		end else begin
			bias_ff <= nxt_bias; // R7 R11
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bias_oe_ff <= 1'h0;
		end else begin
			bias_oe_ff <= nxt_bias_oe; // R2
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_ff <= 16'h0000;
		end else begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	assign path_ctl           = path_ff;
	assign switch_bias_output = bias_ff;
	assign switch_bias_oe     = bias_oe_ff;
	assign reg_rdata          = reg_rdata_ff;

	// First edge after reset still shows reset outputs, so output checks skip it except chk_bias_tristate, chk_bias_idle_low and chk_reset_outputs
	chk_bias_tristate: assert property (@(posedge clk) disable iff (rst) // R2
		!$past(ctrl.bias_out_enable)
		|-> !switch_bias_oe)
		else $error("bias output driven while disabled");

	chk_bias_driven: assert property (@(posedge clk) disable iff (rst) // R2
		!$past(rst) && $past(ctrl.bias_out_enable)
		|-> switch_bias_oe)
		else $error("bias output not driven while enabled");

	chk_bias_idle_low: assert property (@(posedge clk) disable iff (rst) // R7
		!$past(seq_active)
		|-> !switch_bias_output)
		else $error("bias high outside a sequence");

	chk_idle_drive_low: assert property (@(posedge clk) disable iff (rst) // R11
		!$past(rst) && $past(ctrl.bias_out_enable && !seq_active)
		|-> switch_bias_oe && !switch_bias_output)
		else $error("enabled bias not driven low when idle");

	chk_single_tx_high: assert property (@(posedge clk) disable iff (rst) // R6
		!$past(rst) && $past(ctrl.port_mode_select && is_tx)
		|-> switch_bias_output)
		else $error("single-port bias not high in transmit");

	chk_single_rx_low: assert property (@(posedge clk) disable iff (rst) // R3 R6
		!$past(rst) && $past(ctrl.port_mode_select && is_rx)
		|-> !switch_bias_output)
		else $error("single-port bias not low in receive");

	chk_invert_ignored: assert property (@(posedge clk) disable iff (rst) // R3
		!$past(rst) && $past(ctrl.port_mode_select)
		|-> switch_bias_output == $past(is_tx))
		else $error("invert bit acted in single-port mode");

	chk_dual_polarity: assert property (@(posedge clk) disable iff (rst) // R10
		!$past(rst) && $past(!ctrl.port_mode_select && seq_active)
		|-> switch_bias_output == ($past(is_tx) ^ $past(ctrl.bias_out_invert)))
		else $error("dual-port bias polarity wrong");

	chk_dual_rx_level: assert property (@(posedge clk) disable iff (rst) // R10
		!$past(rst) && $past(!ctrl.port_mode_select && is_rx)
		|-> switch_bias_output == $past(ctrl.bias_out_invert))
		else $error("dual-port receive bias level wrong");

	chk_single_rx_path: assert property (@(posedge clk) disable iff (rst) // R4
		!$past(rst) && $past(ctrl.port_mode_select && is_rx)
		|-> path_ctl.rx_switch_en && path_ctl.lna_en && !path_ctl.single_pa_en)
		else $error("single-port receive path wrong");

	chk_single_tx_path: assert property (@(posedge clk) disable iff (rst) // R5
		!$past(rst) && $past(ctrl.port_mode_select && is_tx)
		|-> !path_ctl.rx_switch_en && !path_ctl.lna_en && path_ctl.single_pa_en)
		else $error("single-port transmit path wrong");

	chk_dual_path: assert property (@(posedge clk) disable iff (rst) // R8
		!$past(rst) && $past(!ctrl.port_mode_select)
		|-> path_ctl.rx_switch_en && !path_ctl.single_pa_en && path_ctl.dual_pa_en == $past(is_tx))
		else $error("dual-port path wrong");

	chk_pa_only_tx: assert property (@(posedge clk) disable iff (rst) // R5 R8
		!$past(rst) && !$past(is_tx)
		|-> !path_ctl.single_pa_en && !path_ctl.dual_pa_en)
		else $error("transmit amplifier on outside transmit");

	chk_lna_follows_rx: assert property (@(posedge clk) disable iff (rst) // R4 R8
		!$past(rst)
		|-> path_ctl.lna_en == $past(is_rx))
		else $error("LNA enable does not follow receive");

	chk_cca_receive: assert property (@(posedge clk) disable iff (rst) // R4 R8
		!$past(rst) && $past(radio_state == RFPS_CCA)
		|-> path_ctl.lna_en && !path_ctl.single_pa_en && !path_ctl.dual_pa_en)
		else $error("channel assessment not on receive path");

	chk_dual_toggle: assert property (@(posedge clk) disable iff (rst) // R9
		!$past(rst) && $past(!ctrl.port_mode_select && ctrl.bias_out_enable && is_tx) ##1
		!$past(rst) && $past(!ctrl.port_mode_select && is_rx)
		&& $past(ctrl.bias_out_invert) == $past(ctrl.bias_out_invert, 2)
		|-> $changed(switch_bias_output))
		else $error("dual-port bias did not follow direction");

	chk_mode_default: assert property (@(posedge clk) // R1
		$fell(rst)
		|-> !ctrl.port_mode_select && !ctrl.bias_out_enable && !ctrl.bias_out_invert)
		else $error("control bits not reset");

	chk_reset_outputs: assert property (@(posedge clk) // R2
		$fell(rst)
		|-> !switch_bias_oe && !switch_bias_output && path_ctl == '0 && reg_rdata == 16'h0000)
		else $error("outputs not low after reset");

	chk_reg_write: assert property (@(posedge clk) disable iff (rst) // R1
		!$past(rst) && $past(wr_ctrl_b)
		|-> ctrl_b_ff == $past(reg_wdata))
		else $error("control word write lost");

	chk_reg_hold: assert property (@(posedge clk) disable iff (rst) // R1
		!$past(rst) && !$past(wr_ctrl_b)
		|-> ctrl_b_ff == $past(ctrl_b_ff))
		else $error("control word changed without a write");

	chk_reg_readback: assert property (@(posedge clk) disable iff (rst) // R1
		!$past(rst) && $past(sel_ctrl_b)
		|-> reg_rdata == $past(ctrl_b_ff))
		else $error("control word read back wrong");

	chk_reg_unmapped: assert property (@(posedge clk) disable iff (rst) // R1
		!$past(rst) && !$past(sel_ctrl_b)
		|-> reg_rdata == 16'h0000)
		else $error("unmapped address read not zero");
endmodule

// File: dv/rfps_balun_model.sv
// Behavioural external balun node fed by the switched bias pin
`timescale 1ns/1ns
module rfps_balun_model (
	input  wire logic clk,
	input  wire logic bias_oe,
	input  wire logic bias_drv,
	output logic      bias_node
);
	logic last_ff = 1'h0;
	always @(posedge clk) begin
		if (bias_oe) begin
			last_ff <= bias_drv;
		end
	end
	// No pull on the node, so a released pin shows the inverse level
	assign bias_node = bias_oe ? bias_drv : ~last_ff;
endmodule

// File: dv/tb.sv
// Self-checking testbench for the RF port switch block
`timescale 1ns/1ns
module tb;
	import rfps_pkg::*;
	logic                 clk = 0, rst = 1, reg_wr = 0, bias_node, switch_bias_output, switch_bias_oe;
	logic [5:0]           reg_addr = 6'h07;
	logic [15:0]          reg_wdata = 16'h0000, reg_rdata;
	rfps_radio_state_type radio_state = RFPS_IDLE;
	rfps_path_type        path_ctl;
	int                   bad_count = 0, checks = 0, cyc = 0;
	// Row: enable, invert, mode, state, expected oe, expected bias
	logic [7:0] rows [12] = '{8'hAE, 8'hF3, 8'h93, 8'hD2, 8'hCF, 8'h8E, 8'h30, 8'hC2, 8'hA6, 8'hEA, 8'hCB, 8'hEE};
	always #4 clk = ~clk;
	rfps_core dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .radio_state(radio_state), .path_ctl(path_ctl),
		.switch_bias_output(switch_bias_output), .switch_bias_oe(switch_bias_oe));
	rfps_balun_model bal_u (.clk(clk), .bias_oe(switch_bias_oe), .bias_drv(switch_bias_output), .bias_node(bias_node));
	task chk(string n, logic [15:0] e, logic [15:0] s);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask
	task wr(logic [5:0] a, logic [15:0] d);
		@(negedge clk) reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk) reg_wr = 0;
		reg_addr = 6'h07;
		repeat (2) @(negedge clk);
	endtask
	task finish_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		chk("oe", 0, switch_bias_oe);
		chk("rdata", 0, reg_rdata);
		$display("reset done");
		foreach (rows[i]) begin
			radio_state = rfps_radio_state_type'(rows[i][4:2]);
			wr(6'h07, {1'b0, rows[i][7:5], 12'h000});
			chk("oe", rows[i][1], switch_bias_oe);
			if (rows[i][1])
				chk("bias", rows[i][0], bias_node);
			if (radio_state inside {RFPS_RX, RFPS_TX}) begin
				chk("rxsw", !(rows[i][5] && radio_state == RFPS_TX), path_ctl.rx_switch_en);
				chk("lna", radio_state == RFPS_RX, path_ctl.lna_en);
				chk("pa", {rows[i][5], !rows[i][5]} & {2{radio_state == RFPS_TX}},
					{path_ctl.single_pa_en, path_ctl.dual_pa_en});
			end
		end
		$display("table done");
		wr(6'h07, 16'h0FA5);
		chk("rdata", 16'h0FA5, reg_rdata);
		wr(6'h08, 16'h7000);
		chk("oe", 0, switch_bias_oe);
		chk("rdata", 16'h0FA5, reg_rdata);
		reg_addr = 6'h08;
		@(negedge clk) chk("unmapped", 0, reg_rdata);
		rst = 1;
		@(negedge clk) rst = 0;
		reg_addr = 6'h07;
		@(negedge clk) chk("rdata", 0, reg_rdata);
		$display("refusal and reset done");
		finish_test;
	end
endmodule
